// ---- rtl/dtcru_map.svh ----
`ifndef DTCRU_MAP_SVH
`define DTCRU_MAP_SVH
// What this block does
// - auxiliary timer, core timer, shared capture register
// - every timer is sixteen bits wide
// - timers count prescaled clock or external signals
// - prescale codes divide clock by 4..512
// - prescaled ticks drive gated and timer modes
// - gated mode counts only while gate active
// - direction from software bit, optionally pin level
// - core wrap inverts the toggle latch
// - toggle latch clocks aux timer, drives pin
// - core wraps exported as compare timer clock
// - core wrap reloads from capture register, if enabled
// - capture pin edge latches aux timer value
// - optional aux clear right after capture
// - capture also from position count/direction edges
// - counter mode counts external input edges

// register byte offsets on the apb bus
`define DTCRU_OFF_AUX_CTRL   8'h00
`define DTCRU_OFF_CORE_CTRL  8'h04
`define DTCRU_OFF_CAP_CTRL   8'h08
`define DTCRU_OFF_AUX_COUNT  8'h0c
`define DTCRU_OFF_CORE_COUNT 8'h10
`define DTCRU_OFF_CAPTURE_RELOAD_REG     8'h14
`define DTCRU_OFF_STATUS     8'h18

// timer control fields
`define DTCRU_F_PRESC   2:0
`define DTCRU_F_MODE    4:3
`define DTCRU_B_DOWN    5
`define DTCRU_B_EXTDIR  6
`define DTCRU_B_RUN     7
`define DTCRU_B_GATELVL 8
`define DTCRU_F_EDGE    10:9
`define DTCRU_B_RELOAD  11
`define DTCRU_B_TOGOUT  12
`define DTCRU_CTRL_W    13

// capture control fields
`define DTCRU_F_CAPEDGE 1:0
`define DTCRU_B_CLRCAP  2
`define DTCRU_B_POSCNT  3
`define DTCRU_B_POSDIR  4
`define DTCRU_CAP_W     5

// timer modes
`define DTCRU_MODE_TIMER   2'h0
`define DTCRU_MODE_GATED   2'h1
`define DTCRU_MODE_COUNTER 2'h2
`define DTCRU_MODE_LATCH   2'h3

// reset values
`define DTCRU_RST_CTRL  13'h0000
`define DTCRU_RST_CAP   5'h00
`define DTCRU_RST_COUNT 16'h0000

// widths and prescaler
`define DTCRU_TIMER_W   16
`define DTCRU_TIMER_MAX 16'hffff
`define DTCRU_PRESC_CNT_W 9
`define DTCRU_NCODES    8

// synchronised pin positions
`define DTCRU_PIN_AUX_IN   0
`define DTCRU_PIN_CORE_IN  1
`define DTCRU_PIN_AUX_DIR  2
`define DTCRU_PIN_CORE_DIR 3
`define DTCRU_PIN_CAPTURE_IN_PIN    4
`define DTCRU_PIN_POSCNT   5
`define DTCRU_PIN_POSDIR   6
`define DTCRU_NPINS        7
`endif

// ---- rtl/dtcru_pkg.sv ----
`include "dtcru_map.svh"
package dtcru_pkg;
	// whole state of the top: config, counters, latch, bus answer
	typedef struct packed {
		logic [`DTCRU_CTRL_W-1:0]  aux_ctrl;
		logic [`DTCRU_CTRL_W-1:0]  core_ctrl;
		logic [`DTCRU_CAP_W-1:0]   cap_ctrl;
		logic [`DTCRU_TIMER_W-1:0] aux_count;
		logic [`DTCRU_TIMER_W-1:0] core_count;
		logic [`DTCRU_TIMER_W-1:0] capture_reload_reg;
		logic                      toggle;
		logic                      toggle_d;
		logic                      ovf_tick;
		logic                      toggle_out;
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
	} dtcru_top_st_t;

	localparam dtcru_top_st_t DTCRU_TOP_RESET = '{
		aux_ctrl:   `DTCRU_RST_CTRL,
		core_ctrl:  `DTCRU_RST_CTRL,
		cap_ctrl:   `DTCRU_RST_CAP,
		aux_count:  `DTCRU_RST_COUNT,
		core_count: `DTCRU_RST_COUNT,
		capture_reload_reg:     `DTCRU_RST_COUNT,
		default:    '0
	};
endpackage

// ---- rtl/dtcru_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// synchronised pins and prescaler ticks handed to the timer core
interface dtcru_link_if #(
	parameter int N      = 7,
	parameter int NCODES = 8
);
	logic [N-1:0]      level;  // synchronised pin levels
	logic [N-1:0]      rise;   // one-cycle rising edge
	logic [N-1:0]      fall;   // one-cycle falling edge
	logic [NCODES-1:0] tick;   // one tick per prescale code

	modport sync_mp (output level, output rise, output fall);
	modport pre_mp  (output tick);
	modport core_mp (input level, input rise, input fall, input tick);
endinterface
`default_nettype wire

// ---- rtl/dtcru_insync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser plus edge detector for all pin inputs
module dtcru_insync #(
	parameter int N = 7
) (
	// clock and reset
	input wire logic           pclk,
	input wire logic           presetn,
	// raw pins
	input wire logic [N-1:0]   pins_in,
	// clean levels and edges
	dtcru_link_if.sync_mp      link
);
	import dtcru_pkg::*;

	// s1 is metastable territory; only s2 reads it
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
	} dtcru_sync_st_t;

	dtcru_sync_st_t s;      // registered state
	dtcru_sync_st_t next_s; // next state

	if (N < 1) begin : g_chk
		$error("dtcru_insync needs at least one pin");
	end

	// shift chain, edges taken only from s2 against s3
	always_comb begin
		next_s    = s;
		next_s.s1 = pins_in;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// edge detection after the two-flop stage
	assign link.level = s.s2;
	assign link.rise  = s.s2 & ~s.s3;
	assign link.fall  = ~s.s2 & s.s3;
endmodule
`default_nettype wire

// ---- rtl/dtcru_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dtcru_map.svh"
// free-running divider giving one tick per prescale code
module dtcru_prescaler #(
	parameter int CNT_W  = `DTCRU_PRESC_CNT_W,
	parameter int NCODES = `DTCRU_NCODES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// ticks out
	dtcru_link_if.pre_mp link
);
	import dtcru_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} dtcru_pre_st_t;

	dtcru_pre_st_t s;      // registered state
	dtcru_pre_st_t next_s; // next state

	// code k needs a 2^(k+2) divide, so the counter must reach it
	if (CNT_W < NCODES + 1) begin : g_chk
		$error("dtcru_prescaler counter too narrow for the codes");
	end

	always_comb begin
		next_s     = s;
		next_s.cnt = s.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// tick k when the low k+2 bits are all ones: divide by 4,8..512
	always_comb begin
		for (int k = 0; k < NCODES; k++) begin
			link.tick[k] = &(s.cnt | ~((CNT_W'(1) << (k + 2)) - CNT_W'(1)));
		end
	end
endmodule
`default_nettype wire

// ---- rtl/dtcru_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dtcru_map.svh"
// two timers with shared capture/reload register, apb slave
module dtcru_top (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0]     prdata,
	output logic            pready,
	output logic            pslverr,
	// external timer pins
	input wire logic        aux_in_pin,
	input wire logic        core_in_pin,
	input wire logic        aux_ext_direction_pin,
	input wire logic        core_ext_direction_pin,
	input wire logic        capture_in_pin,
	input wire logic        position_count_input,
	input wire logic        position_direction_input,
	// timer outputs
	output logic            toggle_out_pin,
	output logic            compare_clock_tick
);
	import dtcru_pkg::*;

	dtcru_top_st_t s;      // registered state
	dtcru_top_st_t next_s; // next state

	// padding and wrap logic assume these sizes
	if (`DTCRU_TIMER_W != 16 || `DTCRU_NCODES != 8) begin : g_chk
		$error("dtcru_top needs 16-bit timers and 8 codes");
	end

	// pins and ticks from the helpers
	dtcru_link_if #(.N(`DTCRU_NPINS), .NCODES(`DTCRU_NCODES)) link ();

	// each pin takes two edges to reach the timers
	dtcru_insync #(.N(`DTCRU_NPINS)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pins_in ({position_direction_input, position_count_input, capture_in_pin,
			core_ext_direction_pin, aux_ext_direction_pin, core_in_pin, aux_in_pin}),
		.link    (link.sync_mp)
	);

	// shared divider: timers tick in phase, writes never restart it
	dtcru_prescaler #(.CNT_W(`DTCRU_PRESC_CNT_W), .NCODES(`DTCRU_NCODES)) u_pre (
		.pclk    (pclk),
		.presetn (presetn),
		.link    (link.pre_mp)
	);

	// edge select: bit0 rising, bit1 falling, both for either
	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		return (sel[0] & r) | (sel[1] & f);
	endfunction

	// one count step; returns wrap flag above the new value
	// a same-cycle write overrides the stepped value
	function automatic logic [`DTCRU_TIMER_W:0] step(input logic [`DTCRU_TIMER_W-1:0] c,
		input logic down);
		logic [`DTCRU_TIMER_W-1:0] one;
		one = {{(`DTCRU_TIMER_W-1){1'b0}}, 1'b1};
		if (down) begin
			return {c == '0, c - one};
		end else begin
			return {c == `DTCRU_TIMER_MAX, c + one};
		end
	endfunction

	// count request for one timer from its mode
	function automatic logic cnt_en(input logic [`DTCRU_CTRL_W-1:0] ctrl,
		input logic [`DTCRU_NCODES-1:0] tick, input logic lvl, input logic r,
		input logic f, input logic tr, input logic tf, input logic latch_ok);
		logic pt;
		pt = tick[ctrl[`DTCRU_F_PRESC]];
		case (ctrl[`DTCRU_F_MODE])
			`DTCRU_MODE_TIMER: return pt;
			`DTCRU_MODE_GATED: return pt & (lvl == ctrl[`DTCRU_B_GATELVL]);
			`DTCRU_MODE_COUNTER: return edge_hit(ctrl[`DTCRU_F_EDGE], r, f);
			`DTCRU_MODE_LATCH: return latch_ok & edge_hit(ctrl[`DTCRU_F_EDGE], tr, tf);
			default: return 1'b0;
		endcase
	endfunction

	// register read decode; top bit flags an unmapped address
	function automatic logic [32:0] rd_word(input dtcru_top_st_t st, input logic [7:0] a);
		case (a)
			`DTCRU_OFF_AUX_CTRL:   return {1'b0, 19'h0, st.aux_ctrl};
			`DTCRU_OFF_CORE_CTRL:  return {1'b0, 19'h0, st.core_ctrl};
			`DTCRU_OFF_CAP_CTRL:   return {1'b0, 27'h0, st.cap_ctrl};
			`DTCRU_OFF_AUX_COUNT:  return {1'b0, 16'h0, st.aux_count};
			`DTCRU_OFF_CORE_COUNT: return {1'b0, 16'h0, st.core_count};
			`DTCRU_OFF_CAPTURE_RELOAD_REG:     return {1'b0, 16'h0, st.capture_reload_reg};
			`DTCRU_OFF_STATUS:     return {1'b0, 31'h0, st.toggle};
			default:               return {1'b1, 32'h0};
		endcase
	endfunction

	// toggle latch edges, seen one cycle after the latch moves
	// each flip gives exactly one edge to the aux timer
	logic tog_rise; // latch went high
	logic tog_fall; // latch went low
	assign tog_rise = s.toggle & ~s.toggle_d;
	assign tog_fall = ~s.toggle & s.toggle_d;

	// effective directions: software bit xor enabled pin level
	// the pin may turn the direction while counting
	logic core_down; // core counts down
	logic aux_down;  // aux counts down
	assign core_down = s.core_ctrl[`DTCRU_B_DOWN] ^
		(s.core_ctrl[`DTCRU_B_EXTDIR] & link.level[`DTCRU_PIN_CORE_DIR]);
	assign aux_down = s.aux_ctrl[`DTCRU_B_DOWN] ^
		(s.aux_ctrl[`DTCRU_B_EXTDIR] & link.level[`DTCRU_PIN_AUX_DIR]);

	// count enables; core cannot clock from its own latch
	logic core_hit; // core advances this cycle
	logic aux_hit;  // aux advances this cycle
	assign core_hit = s.core_ctrl[`DTCRU_B_RUN] & cnt_en(s.core_ctrl, link.tick,
		link.level[`DTCRU_PIN_CORE_IN], link.rise[`DTCRU_PIN_CORE_IN],
		link.fall[`DTCRU_PIN_CORE_IN], 1'b0, 1'b0, 1'b0);
	assign aux_hit = s.aux_ctrl[`DTCRU_B_RUN] & cnt_en(s.aux_ctrl, link.tick,
		link.level[`DTCRU_PIN_AUX_IN], link.rise[`DTCRU_PIN_AUX_IN],
		link.fall[`DTCRU_PIN_AUX_IN], tog_rise, tog_fall, 1'b1);

	// step results
	logic [`DTCRU_TIMER_W:0] core_step; // {wrap, value}
	logic [`DTCRU_TIMER_W:0] aux_step;  // {wrap, value}
	logic                    core_wrap; // core over/underflow now
	assign core_step = step(s.core_count, core_down);
	assign aux_step  = step(s.aux_count, aux_down);
	assign core_wrap = core_hit & core_step[`DTCRU_TIMER_W];

	// capture trigger from capture pin or position timer inputs
	// position inputs trigger on either edge
	logic cap_trig;
	assign cap_trig = edge_hit(s.cap_ctrl[`DTCRU_F_CAPEDGE], link.rise[`DTCRU_PIN_CAPTURE_IN_PIN],
		link.fall[`DTCRU_PIN_CAPTURE_IN_PIN])
		| (s.cap_ctrl[`DTCRU_B_POSCNT] &
		(link.rise[`DTCRU_PIN_POSCNT] | link.fall[`DTCRU_PIN_POSCNT]))
		| (s.cap_ctrl[`DTCRU_B_POSDIR] &
		(link.rise[`DTCRU_PIN_POSDIR] | link.fall[`DTCRU_PIN_POSDIR]));

	// apb phases: answer is prepared in setup, taken in access
	// no wait states: the answer stands in the first access cycle
	logic apb_setup; // setup cycle of a transfer
	logic apb_wr;    // write completes at this edge
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & s.pready & pwrite;

	// next-state logic; order sets priority: count, then write, then capture
	always_comb begin
		next_s          = s;
		next_s.toggle_d = s.toggle;
		next_s.ovf_tick = 1'b0;
		next_s.pready   = 1'b0;
		next_s.pslverr  = 1'b0;
		// core timer with toggle latch and reload
		if (core_hit) begin
			next_s.core_count = core_step[`DTCRU_TIMER_W-1:0];
			if (core_step[`DTCRU_TIMER_W]) begin
				next_s.toggle   = ~s.toggle;
				next_s.ovf_tick = 1'b1;
				// reload reads capture_reload_reg before a same-cycle capture
				if (s.core_ctrl[`DTCRU_B_RELOAD]) begin
					next_s.core_count = s.capture_reload_reg;
				end
			end
		end
		// aux timer; its wraps have no side effect
		if (aux_hit) begin
			next_s.aux_count = aux_step[`DTCRU_TIMER_W-1:0];
		end
		// software writes win over counting
		if (apb_wr) begin
			case (paddr)
				`DTCRU_OFF_AUX_CTRL:   next_s.aux_ctrl   = pwdata[`DTCRU_CTRL_W-1:0];
				`DTCRU_OFF_CORE_CTRL:  next_s.core_ctrl  = pwdata[`DTCRU_CTRL_W-1:0];
				`DTCRU_OFF_CAP_CTRL:   next_s.cap_ctrl   = pwdata[`DTCRU_CAP_W-1:0];
				`DTCRU_OFF_AUX_COUNT:  next_s.aux_count  = pwdata[`DTCRU_TIMER_W-1:0];
				`DTCRU_OFF_CORE_COUNT: next_s.core_count = pwdata[`DTCRU_TIMER_W-1:0];
				`DTCRU_OFF_CAPTURE_RELOAD_REG:     next_s.capture_reload_reg     = pwdata[`DTCRU_TIMER_W-1:0];
				default:               next_s.pslverr    = 1'b0; // status is read-only
			endcase
		end
		// capture wins over writes so no hardware event is lost
		if (cap_trig) begin
			next_s.capture_reload_reg = s.aux_count;
			if (s.cap_ctrl[`DTCRU_B_CLRCAP]) begin
				next_s.aux_count = '0;
			end
		end
		// pin follows latch when enabled, low otherwise
		next_s.toggle_out = s.core_ctrl[`DTCRU_B_TOGOUT] & next_s.toggle;
		// bus answer registered so outputs come from flops
		// one decode serves reads and writes, so errors agree
		if (apb_setup) begin
			next_s.pready                  = 1'b1;
			{next_s.pslverr, next_s.prdata} = rd_word(s, paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= DTCRU_TOP_RESET;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from state
	// prdata and pslverr only mean something with pready
	assign prdata             = s.prdata;
	assign pready             = s.pready;
	assign pslverr            = s.pslverr;
	assign toggle_out_pin     = s.toggle_out;
	assign compare_clock_tick = s.ovf_tick;

	// write to the core or aux counter at this edge
	logic wr_core;
	logic wr_aux;
	assign wr_core = apb_wr & (paddr == `DTCRU_OFF_CORE_COUNT);
	assign wr_aux  = apb_wr & (paddr == `DTCRU_OFF_AUX_COUNT);

	// rule checks on one clock; reset disables them
	// so no $past reaches back into reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_presc_div4: assert property (link.tick[0] |=> !link.tick[0] [*3] ##1 link.tick[0])
		else $error("code 0 tick is not every fourth cycle");

	a_wrap_up: assert property (core_hit && !core_down && s.core_count == 16'hffff &&
		!s.core_ctrl[`DTCRU_B_RELOAD] && !wr_core |=> s.core_count == 16'h0000)
		else $error("core did not wrap to zero on overflow");

	a_wrap_down: assert property (core_hit && core_down && s.core_count == 16'h0000 &&
		!s.core_ctrl[`DTCRU_B_RELOAD] && !wr_core |=> s.core_count == 16'hffff)
		else $error("core did not wrap to ffff on underflow");

	a_count_down: assert property (core_hit && core_down && !core_wrap && !wr_core
		|=> s.core_count == 16'($past(s.core_count) - 16'h0001))
		else $error("core did not step down by one");

	a_latch_flip: assert property (core_wrap |=> s.toggle != $past(s.toggle))
		else $error("toggle latch did not invert on wrap");

	a_latch_still: assert property (!core_wrap |=> s.toggle == $past(s.toggle))
		else $error("toggle latch moved without wrap");

	a_ovf_export: assert property (core_wrap |=> compare_clock_tick ##1 !compare_clock_tick)
		else $error("compare clock tick missing or too long");

	a_reload_val: assert property (core_wrap && s.core_ctrl[`DTCRU_B_RELOAD] && !wr_core
		|=> s.core_count == $past(s.capture_reload_reg))
		else $error("core not reloaded from capture register");

	a_capture_val: assert property (cap_trig |=> s.capture_reload_reg == $past(s.aux_count))
		else $error("capture register missed aux value");

	a_clear_cap: assert property (cap_trig && s.cap_ctrl[`DTCRU_B_CLRCAP]
		|=> s.aux_count == 16'h0000)
		else $error("aux not cleared after capture");

	a_gate_hold: assert property (s.core_ctrl[`DTCRU_F_MODE] == `DTCRU_MODE_GATED &&
		link.level[`DTCRU_PIN_CORE_IN] != s.core_ctrl[`DTCRU_B_GATELVL] && !wr_core
		|=> $stable(s.core_count))
		else $error("gated core counted with gate closed");

	a_pin_count: assert property (s.aux_ctrl[`DTCRU_B_RUN] && !cap_trig && !wr_aux &&
		s.aux_ctrl[`DTCRU_F_MODE] == `DTCRU_MODE_COUNTER && !link.rise[`DTCRU_PIN_AUX_IN]
		&& !link.fall[`DTCRU_PIN_AUX_IN] |=> $stable(s.aux_count))
		else $error("counter mode moved without an input edge");

	a_apb_ready: assert property (apb_setup |=> pready ##1 !pready)
		else $error("apb answer not exactly one access cycle");

	a_pin_follow: assert property (s.core_ctrl[`DTCRU_B_TOGOUT]
		|=> toggle_out_pin == s.toggle)
		else $error("toggle pin does not follow the latch");

	a_pin_quiet: assert property (!s.core_ctrl[`DTCRU_B_TOGOUT] |=> !toggle_out_pin)
		else $error("toggle pin driven while disabled");

	a_latch_clk: assert property (s.aux_ctrl[`DTCRU_B_RUN] && (tog_rise || tog_fall) &&
		s.aux_ctrl[`DTCRU_F_MODE] == `DTCRU_MODE_LATCH && s.aux_ctrl[`DTCRU_F_EDGE] == 2'h3
		&& !aux_down && !cap_trig && !wr_aux
		|=> s.aux_count == 16'($past(s.aux_count) + 16'h0001))
		else $error("aux missed a toggle latch edge");

	a_aux_down: assert property (aux_hit && aux_down && !cap_trig && !wr_aux
		|=> s.aux_count == 16'($past(s.aux_count) - 16'h0001))
		else $error("aux did not step down by one");

	a_unmapped: assert property (apb_setup && paddr > `DTCRU_OFF_STATUS |=> pslverr)
		else $error("unmapped address answered without error");
endmodule
`default_nettype wire

// ---- testbench/dtcru_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dtcru_map.svh"
// far side: event, gate, direction, capture and neighbour timer lines
module dtcru_far_model (
	// clock
	input wire logic                    pclk,
	// driven pin levels
	output var logic [`DTCRU_NPINS-1:0] pins
);
	// all lines idle low, as a quiet sensor leaves them
	initial begin
		pins = '0;
	end

	// move one line just after an edge, then hold it well past the sync flops
	task automatic set(input int idx, input logic lvl);
		@(posedge pclk);
		pins[idx] <= lvl;
		repeat (5) @(posedge pclk);
	endtask

	// one clean high pulse, edges far enough apart to stay distinct
	task automatic pulse(input int idx);
		set(idx, 1'b1);
		set(idx, 1'b0);
	endtask
endmodule
`default_nettype wire

// ---- testbench/dual_timer_capture_reload_unit_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dtcru_map.svh"
// self-checking bench for the two-timer capture/reload block
module dual_timer_capture_reload_unit_test;
	import dtcru_pkg::*;
	// control bit patterns; single bits from the shared field map, mode and edge fields by bit position
	localparam logic [31:0] RUN  = 32'h1 << `DTCRU_B_RUN;
	localparam logic [31:0] DOWN = 32'h1 << `DTCRU_B_DOWN;
	localparam logic [31:0] EXTD = 32'h1 << `DTCRU_B_EXTDIR;
	localparam logic [31:0] GLVL = 32'h1 << `DTCRU_B_GATELVL;
	localparam logic [31:0] RELD = 32'h1 << `DTCRU_B_RELOAD;
	localparam logic [31:0] TOGO = 32'h1 << `DTCRU_B_TOGOUT;
	localparam logic [31:0] MGAT = 32'h1 << 3;
	localparam logic [31:0] MCNT = 32'h2 << 3;
	localparam logic [31:0] MLAT = 32'h3 << 3;
	localparam logic [31:0] ERIS = 32'h1 << 9;
	localparam logic [31:0] EBTH = 32'h3 << 9;

	// clock, reset and apb master side
	logic                    pclk;
	logic                    presetn;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [7:0]              paddr;
	logic [31:0]             pwdata;
	wire logic [31:0]        prdata;
	wire logic               pready;
	wire logic               pslverr;
	// pins from the far side model, block outputs
	wire logic [`DTCRU_NPINS-1:0] pins;
	wire logic               toggle_out_pin;
	wire logic               compare_clock_tick;
	// bookkeeping
	int                      bad_count = 0;
	int                      tests_run = 0;
	int                      ticks     = 0;
	int                      cyc       = 0;
	int                      last_cyc  = 0;
	int                      tick_gap  = 0;

	dtcru_top DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.aux_in_pin(pins[`DTCRU_PIN_AUX_IN]), .core_in_pin(pins[`DTCRU_PIN_CORE_IN]),
		.aux_ext_direction_pin(pins[`DTCRU_PIN_AUX_DIR]),
		.core_ext_direction_pin(pins[`DTCRU_PIN_CORE_DIR]),
		.capture_in_pin(pins[`DTCRU_PIN_CAPTURE_IN_PIN]),
		.position_count_input(pins[`DTCRU_PIN_POSCNT]),
		.position_direction_input(pins[`DTCRU_PIN_POSDIR]),
		.toggle_out_pin(toggle_out_pin), .compare_clock_tick(compare_clock_tick)
	);

	dtcru_far_model u_far (
		.pclk(pclk),
		.pins(pins)
	);

	// 200 mhz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// count core wraps seen on the compare clock pin, and their spacing
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (compare_clock_tick === 1'b1) begin
			ticks    <= ticks + 1;
			tick_gap <= cyc - last_cyc;
			last_cyc <= cyc;
		end
	end

	// verdict, reached from the main sequence or from a spent wait
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// single compare for every value checked
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin
			bad_count++;
			complete_run();
		end
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(what, exp, q);
	endtask

	// bounded wait for the wrap count to reach a target
	task automatic wait_ticks(input int target);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(posedge pclk);
			#1;
			if (ticks >= target) break;
		end
		if (i == 3000) begin
			bad_count++;
			complete_run();
		end
	endtask

	// reset values, width of stored fields, read-only and unmapped places
	task automatic t_reset_map;
		logic [31:0] q;
		logic        e;
		for (int a = 0; a < 7; a++) begin
			rd(8'(a * 4), 32'h0, "reset value");
		end
		chk("toggle pin at reset", 32'h0, {31'h0, toggle_out_pin});
		apb(1'b0, 8'h1c, 32'h0, q, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		wr(`DTCRU_OFF_CORE_COUNT, 32'hffffffff);
		rd(`DTCRU_OFF_CORE_COUNT, 32'h0000ffff, "core count width");
		wr(`DTCRU_OFF_CAP_CTRL, 32'hffffffff);
		rd(`DTCRU_OFF_CAP_CTRL, 32'h0000001f, "capture ctrl");
		wr(`DTCRU_OFF_CAP_CTRL, 32'h0);
		wr(`DTCRU_OFF_STATUS, 32'h1);
		rd(`DTCRU_OFF_STATUS, 32'h0, "status is read only");
	endtask

	// every prescale code: reload from ffff makes one wrap per prescaled tick
	task automatic t_prescale;
		logic lvl;
		int   t;
		for (int k = 0; k < 8; k++) begin
			wr(`DTCRU_OFF_CAPTURE_RELOAD_REG, 32'hffff);
			wr(`DTCRU_OFF_CORE_COUNT, 32'hffff);
			wr(`DTCRU_OFF_CORE_CTRL, RUN | RELD | TOGO | 32'(k));
			t = ticks;
			wait_ticks(t + 1);
			lvl = toggle_out_pin;
			wait_ticks(t + 2);
			chk("wrap spacing", 32'(4 << k), tick_gap);
			chk("toggle pin", {31'h0, ~lvl}, {31'h0, toggle_out_pin});
			wr(`DTCRU_OFF_CORE_CTRL, 32'h0);
		end
	endtask

	// direction from software bit, pin, and pin ignored when not enabled
	task automatic t_direction;
		logic [31:0] ctl [5] = '{RUN | EXTD, RUN | EXTD, RUN | DOWN, RUN, RUN | DOWN | EXTD};
		logic        pin [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		logic [31:0] st  [5] = '{32'h3, 32'hfffd, 32'h2, 32'h3, 32'hfffd};
		logic [31:0] ex  [5] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h1};
		int          t;
		for (int c = 0; c < 5; c++) begin
			u_far.set(`DTCRU_PIN_CORE_DIR, pin[c]);
			wr(`DTCRU_OFF_CORE_COUNT, st[c]);
			t = ticks;
			wr(`DTCRU_OFF_CORE_CTRL, ctl[c]);
			repeat (60) @(posedge pclk);
			chk("wraps for direction", ex[c], 32'(ticks - t));
			wr(`DTCRU_OFF_CORE_CTRL, 32'h0);
		end
		u_far.set(`DTCRU_PIN_CORE_DIR, 1'b0);
	endtask

	// gated timer and external counter mode on the core input pin
	task automatic t_gate_count;
		int t;
		wr(`DTCRU_OFF_CORE_COUNT, 32'hffff);
		t = ticks;
		wr(`DTCRU_OFF_CORE_CTRL, RUN | MGAT | GLVL);
		repeat (60) @(posedge pclk);
		chk("gate closed", 32'h0, 32'(ticks - t));
		u_far.set(`DTCRU_PIN_CORE_IN, 1'b1);
		repeat (20) @(posedge pclk);
		chk("gate open", 32'h1, 32'(ticks - t));
		wr(`DTCRU_OFF_CORE_CTRL, 32'h0);
		u_far.set(`DTCRU_PIN_CORE_IN, 1'b0);
		wr(`DTCRU_OFF_CORE_COUNT, 32'hffff);
		t = ticks;
		wr(`DTCRU_OFF_CORE_CTRL, RUN | MCNT | ERIS);
		repeat (60) @(posedge pclk);
		chk("no input edge", 32'h0, 32'(ticks - t));
		u_far.pulse(`DTCRU_PIN_CORE_IN);
		chk("one rising edge", 32'h1, 32'(ticks - t));
		wr(`DTCRU_OFF_CORE_CTRL, 32'h0);
	endtask

	// capture from the pin with clear, then from the neighbour inputs
	task automatic t_capture;
		wr(`DTCRU_OFF_AUX_COUNT, 32'h1234);
		wr(`DTCRU_OFF_CAP_CTRL, 32'h1 | 32'h4);
		u_far.pulse(`DTCRU_PIN_CAPTURE_IN_PIN);
		rd(`DTCRU_OFF_CAPTURE_RELOAD_REG, 32'h1234, "pin capture");
		rd(`DTCRU_OFF_AUX_COUNT, 32'h0, "clear after capture");
		wr(`DTCRU_OFF_AUX_COUNT, 32'ha5);
		wr(`DTCRU_OFF_CAP_CTRL, 32'h8);
		u_far.pulse(`DTCRU_PIN_POSCNT);
		rd(`DTCRU_OFF_CAPTURE_RELOAD_REG, 32'ha5, "count input capture");
		rd(`DTCRU_OFF_AUX_COUNT, 32'ha5, "no clear");
		wr(`DTCRU_OFF_AUX_COUNT, 32'h5a);
		wr(`DTCRU_OFF_CAP_CTRL, 32'h10);
		u_far.pulse(`DTCRU_PIN_POSDIR);
		rd(`DTCRU_OFF_CAPTURE_RELOAD_REG, 32'h5a, "direction input capture");
		wr(`DTCRU_OFF_AUX_COUNT, 32'h77);
		wr(`DTCRU_OFF_CAP_CTRL, 32'h0);
		u_far.pulse(`DTCRU_PIN_CAPTURE_IN_PIN);
		rd(`DTCRU_OFF_CAPTURE_RELOAD_REG, 32'h5a, "capture disabled");
	endtask

	// aux timer counts both edges of the core toggle latch
	task automatic t_chain;
		int t;
		wr(`DTCRU_OFF_CAPTURE_RELOAD_REG, 32'hffff);
		wr(`DTCRU_OFF_CORE_COUNT, 32'hffff);
		wr(`DTCRU_OFF_AUX_COUNT, 32'h0);
		wr(`DTCRU_OFF_AUX_CTRL, RUN | MLAT | EBTH);
		t = ticks;
		wr(`DTCRU_OFF_CORE_CTRL, RUN | RELD);
		wait_ticks(t + 5);
		wr(`DTCRU_OFF_CORE_CTRL, 32'h0);
		repeat (8) @(posedge pclk);
		rd(`DTCRU_OFF_AUX_COUNT, 32'(ticks - t), "aux latch clock");
		wr(`DTCRU_OFF_AUX_CTRL, 32'h0);
	endtask

	// aux counter mode on both edges, direction from its pin
	task automatic t_aux_pins;
		wr(`DTCRU_OFF_AUX_COUNT, 32'h10);
		wr(`DTCRU_OFF_AUX_CTRL, RUN | MCNT | EBTH | EXTD);
		u_far.pulse(`DTCRU_PIN_AUX_IN);
		rd(`DTCRU_OFF_AUX_COUNT, 32'h12, "aux up");
		u_far.set(`DTCRU_PIN_AUX_DIR, 1'b1);
		u_far.pulse(`DTCRU_PIN_AUX_IN);
		rd(`DTCRU_OFF_AUX_COUNT, 32'h10, "aux down");
		wr(`DTCRU_OFF_AUX_CTRL, 32'h0);
		u_far.set(`DTCRU_PIN_AUX_DIR, 1'b0);
	endtask

	// main sequence
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_map();
		t_prescale();
		t_direction();
		t_gate_count();
		t_capture();
		t_aux_pins();
		t_chain();
		complete_run();
	end
endmodule
`default_nettype wire
